// ### ast_top.sv
`timescale 1ns/1ps
// Functional notes
// R1 - Eight or nine data bits, ninth from tx_ninth_bit
// R2 - Software enables, reads status, writes data
// R3 - Idle preamble precedes first transmitted character
// R4 - Low start bit first, high stop last
// R5 - tx_empty on handoff; irq with enable
// R6 - Line idles high when nothing shifts
// R7 - Clearing serial_enable releases both pins
// R8 - send_break loads zero break, length by selects
// R9 - Breaks repeat; then at least one high
// R10 - Short break: ten or eleven zeros
// R11 - Long break: eleven or twelve zeros
// R12 - Break sets frame, full, break; clears data
// R13 - Idle character all ones, length by selection
// R14 - tx_enable clear finishes current character first
// R15 - tx_enable toggle queues one idle character
// R16 - tx_invert inverts every transmitted level
// R17 - tx_done when all empty; irq with enable
// R18 - rx_ninth_bit holds bit 8 or bit 7
// R19 - Baud source: bus clock or crystal clock
// R20 - Independent tx and rx, shared baud generator
// R21 - Receiver samples at sixteen times baud
// R22 - Received word to data reg, rx_full, irq
// R23 - Missing stop high sets frame_error_flag
// R24 - Least significant bit first, ninth before stop
// R25 - Reset clears flags, releases transmit pin
module ast_top import ast_pkg::*; (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Avalon-MM slave
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Serial pins
   input  wire logic        rxd_i,
   output logic             txd_o,
   output logic             txd_oe,
   // Interrupt requests
   output logic             tx_irq,
   output logic             rx_irq
);
   typedef enum logic [2:0] {TX_IDLE, TX_CHAR, TX_IDLECH, TX_BREAK, TX_TAIL} ast_tx_e;

   logic        ack_r, w_go, r_go;
   logic        ser_en_r, len9_r, inv_r;
   logic        te_r, re_r, sbk_r, tie_r, tx_done_irq_en_r, rie_r;
   logic        t8_r, r8_r, lb_r, src_r;
   logic [7:0]  baud_r, tdr_r, rdr_r;
   logic        tx_empty_r, rx_full_r, fe_r, nf_r, ovr_r, bkf_r;
   logic        arm_tx_r, arm_rx_r, te_prev_r, idle_q_r;
   logic [2:0]  sync_r;
   logic        rx_f_r;
   logic [1:0]  pre_r;
   logic [7:0]  div_r;
   logic [3:0]  rt16_r;
   logic        src_tick, rt_tick, bit_tick;
   ast_tx_e     st_r, nxt_st;
   logic [11:0] sh_r, nxt_sh;
   logic [3:0]  bits_r, nxt_bits;
   logic        pick, tx_done, rx_done, rx_busy;
   logic [31:0] rd_val;
   ast_rx_s     rx_res;

   // One wait state per access; read data settle before release
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   assign w_go = avs_write & ack_r;
   assign r_go = avs_read & ack_r;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ack_r        <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         ack_r <= (avs_read | avs_write) & ~ack_r;
         if (avs_read & ~ack_r) begin
            avs_readdata <= rd_val;
         end
      end
   end

   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (avs_address)
         ADDR_CTL1: begin
            rd_val[C1_SER_EN] = ser_en_r;
            rd_val[C1_LEN9]   = len9_r;
            rd_val[C1_INV]    = inv_r;
         end
         ADDR_CTL2: begin
            rd_val[C2_TE]   = te_r;
            rd_val[C2_RE]   = re_r;
            rd_val[C2_SBK]  = sbk_r;
            rd_val[C2_TIE]  = tie_r;
            rd_val[C2_TX_DONE_IRQ_EN] = tx_done_irq_en_r;
            rd_val[C2_RIE]  = rie_r;
         end
         ADDR_CTL3: begin
            rd_val[C3_T8] = t8_r;
            rd_val[C3_R8] = r8_r;
         end
         ADDR_STAT1: begin
            rd_val[S1_TEMPTY] = tx_empty_r;
            rd_val[S1_TDONE]  = tx_done;
            rd_val[S1_RFULL]  = rx_full_r;
            rd_val[S1_NOISE]  = nf_r;
            rd_val[S1_FRAME]  = fe_r;
            rd_val[S1_OVR]    = ovr_r;
         end
         ADDR_STAT2: begin
            rd_val[S2_BRK]   = bkf_r;
            rd_val[S2_RBUSY] = rx_busy;
         end
         ADDR_DATA:   rd_val[7:0] = rdr_r;
         ADDR_BAUD:   rd_val[BR_LONG:0] = {lb_r, baud_r};
         ADDR_SYSCFG: rd_val[SC_SRC] = src_r;
         default:     rd_val = 32'h0000_0000;
      endcase
   end

   // Control registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin // R25
         {ser_en_r, len9_r, inv_r}          <= 3'h0;
         {te_r, re_r, sbk_r}                <= 3'h0;
         {tie_r, tx_done_irq_en_r, rie_r, t8_r, lb_r} <= 5'h00;
         baud_r <= BAUD_RST;
         src_r  <= SRC_RST;
      end else if (w_go) begin
         unique case (avs_address)
            ADDR_CTL1: begin
               ser_en_r <= avs_writedata[C1_SER_EN];
               len9_r   <= avs_writedata[C1_LEN9];
               inv_r    <= avs_writedata[C1_INV];
            end
            ADDR_CTL2: begin
               te_r   <= avs_writedata[C2_TE];
               re_r   <= avs_writedata[C2_RE];
               sbk_r  <= avs_writedata[C2_SBK];
               tie_r  <= avs_writedata[C2_TIE];
               tx_done_irq_en_r <= avs_writedata[C2_TX_DONE_IRQ_EN];
               rie_r  <= avs_writedata[C2_RIE];
            end
            ADDR_CTL3: t8_r <= avs_writedata[C3_T8];
            ADDR_BAUD: begin
               baud_r <= avs_writedata[7:0];
               lb_r   <= avs_writedata[BR_LONG];
            end
            ADDR_SYSCFG: src_r <= avs_writedata[SC_SRC];
            default: ;
         endcase
      end
   end

   // Shared baud generator; clear source bit means crystal rate
   assign src_tick = src_r ? (pre_r == BUS_PRE_MAX) : 1'b1; // R19
   assign rt_tick  = src_tick && (div_r == baud_r);
   assign bit_tick = rt_tick && (rt16_r == RT_LAST);

   always_ff @(posedge clk) begin
      if (!reset_n || !ser_en_r) begin
         pre_r  <= 2'h0;
         div_r  <= 8'h00;
         rt16_r <= 4'h0;
      end else begin
         pre_r <= pre_r + 2'h1;
         if (src_tick) begin
            div_r <= rt_tick ? 8'h00 : div_r + 8'h01;
         end
         if (rt_tick) begin
            rt16_r <= rt16_r + 4'h1; // R20
         end
      end
   end

   // Next transmit unit; break beats queued idle beats data
   assign pick = ser_en_r && bit_tick && (st_r == TX_IDLE || bits_r == 4'h1);

   always_comb begin
      nxt_st   = TX_IDLE;
      nxt_sh   = 12'hFFF;
      nxt_bits = 4'h1;
      if (te_r && sbk_r) begin
         nxt_st   = TX_BREAK; // R8 R9
         nxt_sh   = 12'h000;
         nxt_bits = BASE_BITS + {3'h0, len9_r} + {3'h0, lb_r};
      end else if (st_r == TX_BREAK) begin
         nxt_st = TX_TAIL; // R9
      end else if (te_r && idle_q_r) begin
         nxt_st   = TX_IDLECH; // R3 R13
         nxt_bits = BASE_BITS + {3'h0, len9_r};
      end else if (te_r && !tx_empty_r) begin
         nxt_st   = TX_CHAR; // R1 R4 R24
         nxt_sh   = {2'h3, len9_r ? t8_r : 1'b1, tdr_r, 1'b0};
         nxt_bits = BASE_BITS + {3'h0, len9_r};
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n || !ser_en_r) begin
         st_r   <= TX_IDLE;
         sh_r   <= 12'hFFF;
         bits_r <= 4'h0;
      end else if (pick) begin // R14
         st_r   <= nxt_st;
         sh_r   <= nxt_sh;
         bits_r <= nxt_bits;
      end else if (bit_tick && st_r != TX_IDLE) begin
         sh_r   <= {1'b1, sh_r[11:1]};
         bits_r <= bits_r - 4'h1;
      end
   end

   // Preamble and mid-frame re-enable both queue one idle unit
   always_ff @(posedge clk) begin
      if (!reset_n || !ser_en_r) begin
         te_prev_r <= 1'b0;
         idle_q_r  <= 1'b0;
      end else begin
         te_prev_r <= te_r;
         if (te_r && !te_prev_r) begin
            idle_q_r <= 1'b1; // R3 R15
         end else if (pick && nxt_st == TX_IDLECH) begin
            idle_q_r <= 1'b0;
         end
      end
   end

   // Transmit buffer; a write in the handoff cycle keeps the new word
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tdr_r      <= 8'h00;
         tx_empty_r <= 1'b1;
         arm_tx_r   <= 1'b0;
      end else begin
         if (r_go && avs_address == ADDR_STAT1) begin
            arm_tx_r <= 1'b1;
         end
         if (w_go && avs_address == ADDR_DATA) begin
            tdr_r    <= avs_writedata[7:0];
            arm_tx_r <= 1'b0;
         end
         if (w_go && avs_address == ADDR_DATA && arm_tx_r) begin
            tx_empty_r <= 1'b0; // R2
         end else if (pick && nxt_st == TX_CHAR) begin
            tx_empty_r <= 1'b1; // R5
         end
      end
   end

   assign tx_done = (st_r == TX_IDLE) && tx_empty_r && !idle_q_r && !(te_r && sbk_r); // R17
   assign tx_irq  = (tx_empty_r && tie_r) || (tx_done && tx_done_irq_en_r); // R5 R17

   // Output line, inverted as a whole
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         txd_o <= 1'b1;
      end else begin
         txd_o <= ((st_r == TX_IDLE) ? 1'b1 : sh_r[0]) ^ inv_r; // R6 R16
      end
   end

   assign txd_oe = ser_en_r; // R7 R25

   // Pin synchroniser; change accepted when stages two and three agree
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sync_r <= 3'h7;
         rx_f_r <= 1'b1;
      end else begin
         sync_r <= {sync_r[1:0], rxd_i};
         if (sync_r[1] == sync_r[2]) begin
            rx_f_r <= sync_r[2];
         end
      end
   end

   ast_rx u_rx (
      .clk      (clk),
      .reset_n  (reset_n),
      .rx_en    (ser_en_r & re_r), // R7
      .rt_tick  (rt_tick),
      .len9     (len9_r),
      .long_brk (lb_r),
      .rx_line  (rx_f_r),
      .done     (rx_done),
      .res      (rx_res),
      .busy     (rx_busy)
   );

   // Receive flags; a new character outranks the clearing read
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdr_r    <= 8'h00;
         r8_r     <= 1'b0;
         {rx_full_r, fe_r, nf_r, ovr_r, bkf_r} <= 5'h00;
         arm_rx_r <= 1'b0;
      end else begin
         if (r_go && avs_address == ADDR_STAT1) begin
            arm_rx_r <= 1'b1;
         end
         if (r_go && avs_address == ADDR_DATA && arm_rx_r) begin
            {rx_full_r, fe_r, nf_r, ovr_r} <= 4'h0;
            arm_rx_r <= 1'b0;
         end
         if (w_go && avs_address == ADDR_STAT2 && avs_writedata[S2_BRK]) begin
            bkf_r <= 1'b0;
         end
         if (rx_done && rx_full_r && !(r_go && avs_address == ADDR_DATA && arm_rx_r)) begin
            ovr_r <= 1'b1;
         end else if (rx_done) begin
            rx_full_r <= 1'b1; // R22
            rdr_r     <= rx_res.brk ? 8'h00 : rx_res.data; // R12
            r8_r      <= rx_res.brk ? 1'b0 : rx_res.ninth; // R18
            fe_r      <= rx_res.frame; // R23
            nf_r      <= rx_res.noise;
            bkf_r     <= bkf_r | rx_res.brk; // R12
         end
      end
   end

   assign rx_irq = rx_full_r && rie_r; // R22

   // Checks
   idle_line_a: assert property (@(posedge clk) disable iff (!reset_n) // R6
      (st_r == TX_IDLE && $past(st_r) == TX_IDLE) |=> txd_o == !$past(inv_r))
      else $error("transmit line not idle");
   pin_release_a: assert property (@(posedge clk) disable iff (!reset_n) // R7
      $fell(ser_en_r) |-> !txd_oe ##1 st_r == TX_IDLE && !rx_busy)
      else $error("pins not released");
   empty_handoff_a: assert property (@(posedge clk) disable iff (!reset_n) // R5
      (pick && nxt_st == TX_CHAR && !w_go) |=> tx_empty_r && st_r == TX_CHAR)
      else $error("tx_empty not set on handoff");
   frame_bits_a: assert property (@(posedge clk) disable iff (!reset_n) // R4
      (st_r == TX_CHAR && $changed(bits_r) && bits_r == BASE_BITS + {3'h0, len9_r})
      |-> !sh_r[0] && sh_r[9 + len9_r])
      else $error("bad start or stop bit");
   ninth_tx_a: assert property (@(posedge clk) disable iff (!reset_n) // R1
      (pick && nxt_st == TX_CHAR && len9_r) |=> sh_r[9] == $past(t8_r))
      else $error("ninth bit wrong");
   break_len_a: assert property (@(posedge clk) disable iff (!reset_n) // R8
      (pick && nxt_st == TX_BREAK) |=> sh_r == 12'h000
      && bits_r == BASE_BITS + {3'h0, len9_r} + {3'h0, lb_r})
      else $error("break length wrong");
   break_tail_a: assert property (@(posedge clk) disable iff (!reset_n) // R9
      (pick && st_r == TX_BREAK && !sbk_r) |=> st_r == TX_TAIL && sh_r[0])
      else $error("no high after break");
   reenable_a: assert property (@(posedge clk) disable iff (!reset_n || !ser_en_r) // R15
      $rose(te_r) |=> idle_q_r)
      else $error("idle not queued");
   rx_break_a: assert property (@(posedge clk) disable iff (!reset_n) // R12
      (rx_done && rx_res.brk && !rx_full_r) |=> fe_r && bkf_r && rx_full_r
      && rdr_r == 8'h00 && !r8_r)
      else $error("break flags wrong");
   rx_ninth_a: assert property (@(posedge clk) disable iff (!reset_n) // R18
      (rx_done && !rx_full_r && !len9_r && !rx_res.brk) |=> r8_r == rdr_r[7])
      else $error("rx_ninth_bit copy wrong");
   baud_src_a: assert property (@(posedge clk) disable iff (!reset_n) // R19
      (rt_tick && src_r) |-> pre_r == BUS_PRE_MAX)
      else $error("baud tick off bus rate");
   done_irq_a: assert property (@(posedge clk) disable iff (!reset_n) // R17
      (tx_done && tx_done_irq_en_r) |-> tx_irq)
      else $error("tx_done irq missing");

   char_sent_c: cover property (@(posedge clk) disable iff (!reset_n)
      st_r == TX_CHAR ##1 st_r == TX_IDLE);
   break_rx_c: cover property (@(posedge clk) disable iff (!reset_n)
      rx_done && rx_res.brk);
   rx_char_c: cover property (@(posedge clk) disable iff (!reset_n)
      rx_done && !rx_res.frame);
endmodule : ast_top

// ### ast_pkg.sv
package ast_pkg;
   // Register byte addresses
   localparam logic [4:0] ADDR_CTL1   = 5'h00;
   localparam logic [4:0] ADDR_CTL2   = 5'h04;
   localparam logic [4:0] ADDR_CTL3   = 5'h08;
   localparam logic [4:0] ADDR_STAT1  = 5'h0C;
   localparam logic [4:0] ADDR_STAT2  = 5'h10;
   localparam logic [4:0] ADDR_DATA   = 5'h14;
   localparam logic [4:0] ADDR_BAUD   = 5'h18;
   localparam logic [4:0] ADDR_SYSCFG = 5'h1C;
   // control_reg_one
   localparam int C1_SER_EN  = 0;
   localparam int C1_LEN9    = 1;
   localparam int C1_INV     = 2;
   // control_reg_two
   localparam int C2_TE      = 0;
   localparam int C2_RE      = 1;
   localparam int C2_SBK     = 2;
   localparam int C2_TIE     = 3;
   localparam int C2_TX_DONE_IRQ_EN    = 4;
   localparam int C2_RIE     = 5;
   // control_reg_three
   localparam int C3_T8      = 0;
   localparam int C3_R8      = 1;
   // status_reg_one
   localparam int S1_TEMPTY  = 0;
   localparam int S1_TDONE   = 1;
   localparam int S1_RFULL   = 2;
   localparam int S1_NOISE   = 3;
   localparam int S1_FRAME   = 4;
   localparam int S1_OVR     = 5;
   // status_reg_two
   localparam int S2_BRK     = 0;
   localparam int S2_RBUSY   = 1;
   // baud_rate_reg: divisor in [7:0], long break select
   localparam int BR_LONG    = 8;
   // system_config_reg_two
   localparam int SC_SRC     = 0;
   // Reset values
   localparam logic [7:0] BAUD_RST = 8'h00;
   localparam logic       SRC_RST  = 1'h0;
   // Timing: bus clock is a quarter of the crystal-derived clock
   localparam logic [1:0] BUS_PRE_MAX = 2'h3;
   localparam logic [3:0] RT_LAST     = 4'hF;
   localparam logic [3:0] BASE_BITS   = 4'hA;
   localparam logic [3:0] DATA_BITS   = 4'h8;

   typedef struct packed {
      logic [7:0] data;
      logic       ninth;
      logic       frame;
      logic       noise;
      logic       brk;
   } ast_rx_s;
endpackage : ast_pkg

// ### ast_rx.sv
`timescale 1ns/1ps
module ast_rx import ast_pkg::*; (
   // Clock and reset
   input  wire logic    clk,
   input  wire logic    reset_n,
   // Control
   input  wire logic    rx_en,
   input  wire logic    rt_tick,
   input  wire logic    len9,
   input  wire logic    long_brk,
   // Filtered line
   input  wire logic    rx_line,
   // Result
   output logic         done,
   output ast_rx_s      res,
   output logic         busy
);
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} ast_rx_e;
   ast_rx_e     st_r;
   logic [3:0]  cnt_r;
   logic [3:0]  idx_r;
   logic [1:0]  ones_r;
   logic [1:0]  smp_r;
   logic [11:0] sh_r;
   logic        zero_r;
   logic        noise_r;
   logic [3:0]  rtn;
   logic [2:0]  s3;
   logic        bit_v;
   logic        mixed;
   logic [3:0]  stop_idx;

   assign rtn      = cnt_r + 4'h1;
   assign s3       = {smp_r, rx_line};
   assign bit_v    = (s3[0] & s3[1]) | (s3[0] & s3[2]) | (s3[1] & s3[2]);
   assign mixed    = (s3 != 3'h0) && (s3 != 3'h7);
   assign stop_idx = DATA_BITS + {3'h0, len9};
   assign busy     = (st_r != RX_IDLE);

   always_ff @(posedge clk) begin
      if (!reset_n || !rx_en) begin
         st_r    <= RX_IDLE;
         cnt_r   <= 4'h0;
         idx_r   <= 4'h0;
         ones_r  <= 2'h0;
         smp_r   <= 2'h0;
         sh_r    <= 12'h000;
         zero_r  <= 1'b0;
         noise_r <= 1'b0;
         done    <= 1'b0;
         res     <= '0;
      end else begin
         done <= 1'b0;
         if (rt_tick) begin
            cnt_r <= rtn;
            unique case (st_r)
               RX_IDLE: begin
                  // A start needs three ones before the falling edge
                  if (rx_line) begin
                     ones_r <= (ones_r == 2'h3) ? 2'h3 : ones_r + 2'h1;
                  end else begin
                     ones_r <= 2'h0;
                     if (ones_r == 2'h3) begin
                        st_r    <= RX_START;
                        cnt_r   <= 4'h1;
                        idx_r   <= 4'h0;
                        zero_r  <= 1'b1;
                        noise_r <= 1'b0;
                     end
                  end
               end
               RX_START: begin // R21
                  if (rtn == 4'h3 || rtn == 4'h5) begin
                     smp_r <= {smp_r[0], rx_line};
                  end
                  if (rtn == 4'h7) begin
                     noise_r <= mixed;
                     if (bit_v) begin
                        st_r <= RX_IDLE;
                     end
                  end
                  if (rtn == 4'h0) begin
                     st_r <= RX_BITS;
                  end
               end
               RX_BITS: begin
                  if (rtn == 4'h8 || rtn == 4'h9) begin
                     smp_r <= {smp_r[0], rx_line};
                  end
                  if (rtn == 4'hA) begin
                     sh_r[idx_r] <= bit_v; // R24
                     idx_r       <= idx_r + 4'h1;
                     zero_r      <= zero_r & ~bit_v;
                     noise_r     <= noise_r | mixed;
                     // Long break looks one bit past a zero stop position
                     if ((idx_r == stop_idx && (bit_v || !long_brk || !zero_r))
                         || idx_r == stop_idx + 4'h1) begin
                        st_r      <= RX_IDLE;
                        done      <= 1'b1;
                        res.data  <= sh_r[7:0];
                        res.ninth <= len9 ? sh_r[8] : sh_r[7]; // R18
                        res.frame <= (idx_r == stop_idx) ? ~bit_v : 1'b1; // R23
                        res.noise <= noise_r | mixed;
                        res.brk   <= zero_r & ~bit_v; // R10 R11
                     end
                  end
               end
            endcase
         end
      end
   end
endmodule : ast_rx

// ### ast_peer.sv
`timescale 1ns/1ps
module ast_peer (
   // Clock
   input  wire logic clk,
   // Device transmit wire, pulled up when released
   input  wire logic line_i,
   input  wire logic len9,
   // Device receive wire
   output logic      line_o
);
   logic [9:0] got;
   int         frames;
   int         cyc;
   int         start_cyc;

   initial begin
      line_o    = 1'b1;
      got       = 10'h000;
      frames    = 0;
      cyc       = 0;
      start_cyc = 0;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
   end

   // LSB first, one bit each 16 clocks; line returns high afterwards
   task automatic send(input logic [15:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         line_o <= v[i];
         repeat (16) @(posedge clk);
      end
      line_o <= 1'b1;
   endtask : send

   // Mid-bit sampling; blind to a new start until the stop is taken
   initial forever begin
      @(negedge line_i);
      start_cyc = cyc;
      repeat (8) @(posedge clk);
      for (int i = 0; i < (len9 ? 10 : 9); i++) begin
         repeat (16) @(posedge clk);
         got[i] = line_i;
      end
      frames++;
   end
endmodule : ast_peer

// ### async_serial_transceiver_tb.sv
`timescale 1ns/1ps
module async_serial_transceiver_tb import ast_pkg::*; ;
   logic        clk;
   logic        reset_n;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        rxd;
   logic        txd_o;
   logic        txd_oe;
   logic        tx_irq;
   logic        rx_irq;
   logic        len9;
   logic        line;
   logic [31:0] q;
   int          errors;
   int          n_checks;
   int          t0;
   int          nf;

   assign line = txd_oe ? txd_o : 1'b1;

   ast_top uut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rxd_i(rxd), .txd_o(txd_o), .txd_oe(txd_oe),
      .tx_irq(tx_irq), .rx_irq(rx_irq));

   ast_peer peer (.clk(clk), .line_i(line), .len9(len9), .line_o(rxd));

   always #25 clk = ~clk;

   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_of_test

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // Request held until an edge with waitrequest low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
      int k;
      k = 0;
      @(posedge clk);
      avs_address   <= a;
      avs_write     <= w;
      avs_read      <= !w;
      avs_writedata <= d;
      do begin
         @(posedge clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 100);
      if (avs_waitrequest !== 1'b0) begin
         errors++;
      end
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [31:0] r);
      bus(1'b0, a, 32'h0, r);
   endtask : rd

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : wait_cyc

   task automatic wait_rx();
      int k;
      k = 0;
      while (rx_irq !== 1'b1 && k < 3000) begin
         @(negedge clk);
         k++;
      end
      if (rx_irq !== 1'b1) begin
         errors++;
      end
   endtask : wait_rx

   task automatic wait_frames(input int n);
      int k;
      k = 0;
      while (peer.frames < n && k < 3000) begin
         @(negedge clk);
         k++;
      end
      chk("frames", peer.frames, n);
   endtask : wait_frames

   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      len9 = 1'b0;
      errors = 0;
      n_checks = 0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      wait_cyc(1);
      chk("oe_rst", {31'h0, txd_oe}, 32'h0);
      chk("txd_rst", {31'h0, txd_o}, 32'h1);
      rd(ADDR_STAT1, q);
      chk("stat1_rst", q, 32'h3);
      rd(ADDR_CTL2, q);
      chk("ctl2_rst", q, 32'h0);
      rd(5'h02, q);
      chk("unmapped", q, 32'h0);
      wr(ADDR_BAUD, 32'h0);
      wr(ADDR_SYSCFG, 32'h0);
      wr(ADDR_CTL1, 32'h1);
      wr(ADDR_CTL2, 32'h2B);
      t0 = peer.cyc;
      wait_cyc(1);
      chk("oe_on", {31'h0, txd_oe}, 32'h1);
      chk("tx_irq_empty", {31'h0, tx_irq}, 32'h1);
      rd(ADDR_STAT1, q);
      wr(ADDR_DATA, 32'hA5);
      wait_cyc(1);
      chk("tx_irq_full", {31'h0, tx_irq}, 32'h0);
      wait_frames(1);
      chk("frame8", {23'h0, peer.got[8:0]}, 32'h1A5);
      chk("preamble", {31'h0, peer.start_cyc - t0 >= 160}, 32'h1);
      wait_cyc(32);
      chk("idle", {31'h0, txd_o}, 32'h1);
      rd(ADDR_STAT1, q);
      chk("tx_done", q & 32'h3, 32'h3);
      len9 = 1'b1;
      wr(ADDR_CTL1, 32'h3);
      wr(ADDR_CTL3, 32'h1);
      rd(ADDR_STAT1, q);
      wr(ADDR_DATA, 32'h3C);
      wait_frames(2);
      chk("frame9", {22'h0, peer.got}, 32'h33C);
      wait_cyc(32);
      wr(ADDR_CTL2, 32'h2F);
      wait_cyc(100);
      chk("break_low", {31'h0, txd_o}, 32'h0);
      wr(ADDR_CTL2, 32'h2B);
      wait_cyc(400);
      chk("break_end", {31'h0, txd_o}, 32'h1);
      len9 = 1'b0;
      wr(ADDR_CTL1, 32'h1);
      peer.send({6'h1, 8'hC3, 1'b0}, 10);
      wait_rx();
      chk("rx_irq", {31'h0, rx_irq}, 32'h1);
      rd(ADDR_STAT1, q);
      chk("rx_flags", q & 32'h14, 32'h04);
      rd(ADDR_CTL3, q);
      chk("rx_bit7", q & 32'h2, 32'h2);
      rd(ADDR_DATA, q);
      chk("rx_data", q, 32'hC3);
      peer.send({6'h0, 8'h81, 1'b0}, 10);
      wait_rx();
      rd(ADDR_STAT1, q);
      chk("frame_err", q & 32'h14, 32'h14);
      rd(ADDR_DATA, q);
      wait_cyc(40);
      peer.send(16'h0, 11);
      wait_rx();
      rd(ADDR_STAT1, q);
      chk("brk_flags", q & 32'h14, 32'h14);
      rd(ADDR_DATA, q);
      chk("brk_data", q, 32'h0);
      rd(ADDR_STAT2, q);
      chk("brk_flag", q & 32'h1, 32'h1);
      rd(ADDR_CTL3, q);
      chk("brk_ninth", q & 32'h2, 32'h0);
      wr(ADDR_STAT2, 32'h1);
      wr(ADDR_BAUD, 32'h100);
      // Ten zeros then a one is no break in long mode
      peer.send(16'h0400, 11);
      wait_rx();
      rd(ADDR_STAT1, q);
      chk("long_short_fe", q & 32'h14, 32'h14);
      rd(ADDR_DATA, q);
      rd(ADDR_STAT2, q);
      chk("long_short_brk", q & 32'h1, 32'h0);
      peer.send(16'h0, 11);
      wait_rx();
      rd(ADDR_STAT1, q);
      rd(ADDR_DATA, q);
      chk("long_brk_data", q, 32'h0);
      rd(ADDR_STAT2, q);
      chk("long_brk", q & 32'h1, 32'h1);
      wr(ADDR_CTL1, 32'h5);
      wait_cyc(40);
      chk("inv_idle", {31'h0, txd_o}, 32'h0);
      wr(ADDR_CTL1, 32'h0);
      wait_cyc(1);
      chk("oe_off", {31'h0, txd_oe}, 32'h0);
      end_of_test();
   end

   // Whole run is some 2100 cycles; stop well beyond that
   initial begin
      #(60000 * 50);
      errors++;
      end_of_test();
   end
endmodule : async_serial_transceiver_tb
